/* design/ppd_top.sv */
// Pad pull and drive configuration bank with its register port and pad decode
`default_nettype none
module ppd_top
   import ppd_pkg::*;
(
   // Clock and reset
   input  wire logic                  SYS_CLK,
   input  wire logic                  RST_N,
   // Register port
   input  wire logic [ADDR_W-1:0]     ADDR,
   input  wire logic [31:0]           WR_DATA,
   input  wire logic                  WR_EN,
   input  wire logic                  RD_EN,
   output var  logic [31:0]           RD_DATA,
   // Pad controls, one bit per slot, slot = register * 4 + nibble
   output var  logic [SLOT_COUNT-1:0] PAD_PULL_UP,
   output var  logic [SLOT_COUNT-1:0] PAD_PULL_DOWN,
   output var  logic [SLOT_COUNT-1:0] PAD_DRIVE_12MA
);

   ppd_bank_if bank_if ();

   logic [3:0]            wr_hit;
   logic [3:0]            rd_hit;
   logic [SLOT_COUNT-1:0] next_pull_up;
   logic [SLOT_COUNT-1:0] next_pull_down;
   logic [SLOT_COUNT-1:0] next_drive_12ma;

   // Returns hit flag in bit 3 and register index below it
   function automatic logic [3:0] decode_addr(input logic [ADDR_W-1:0] a);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < REG_COUNT; i++) begin
         if (a == REG_OFFSET[i]) begin
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction

   assign wr_hit = decode_addr(ADDR);
   assign rd_hit = decode_addr(ADDR);

   // Upper half-word of write data is dropped
   always_comb begin
      bank_if.wr_sel = '0;
      bank_if.wdata  = WR_DATA[CFG_W-1:0];
      if (WR_EN && wr_hit[3]) begin
         bank_if.wr_sel[wr_hit[2:0]] = 1'b1;
      end
   end

   ppd_bank u_bank (
      .sys_clk (SYS_CLK),
      .rst_n   (RST_N),
      .bus     (bank_if.bank)
   );

   // Read data stand for one cycle only; unmapped addresses read zero
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RD_DATA <= 32'h0;
      end else if (RD_EN && rd_hit[3]) begin
         RD_DATA <= {16'h0, bank_if.value[rd_hit[2:0]]};
      end else begin
         RD_DATA <= 32'h0;
      end
   end

   // Prohibited pull code 11 attaches neither resistor; drive codes other
   // than 11 fall back to the weaker 6 mA so a bad write never overdrives
   always_comb begin
      logic [SLOT_W-1:0] slot;
      logic [1:0]        pull;
      logic [1:0]        drive;
      slot            = '0;
      pull            = PULL_NONE;
      drive           = DRIVE_6MA;
      next_pull_up    = '0;
      next_pull_down  = '0;
      next_drive_12ma = '0;
      for (int r = 0; r < REG_COUNT; r++) begin
         for (int n = 0; n < 4; n++) begin
            slot  = bank_if.value[r][n*SLOT_W +: SLOT_W];
            pull  = slot[PULL_LSB +: 2];
            drive = slot[DRIVE_LSB +: 2];
            next_pull_up[r*4+n]    = (pull == PULL_UP);
            next_pull_down[r*4+n]  = (pull == PULL_DOWN);
            next_drive_12ma[r*4+n] = (drive == DRIVE_12MA);
         end
      end
   end

   // Pads lag the register by one cycle; released with no pull during reset
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PAD_PULL_UP    <= '0;
         PAD_PULL_DOWN  <= '0;
         PAD_DRIVE_12MA <= '0;
      end else begin
         PAD_PULL_UP    <= next_pull_up;
         PAD_PULL_DOWN  <= next_pull_down;
         PAD_DRIVE_12MA <= next_drive_12ma;
      end
   end

endmodule
`default_nettype wire

/* design/ppd_pkg.sv */
// Constants and register map for the pad pull and drive configuration bank
// How it works
// - Pull code 00 none, 01 pull-down, 10 pull-up, 11 prohibited.
// - Drive code 01 gives 6 mA, 11 gives 12 mA; software writes only those.
// - Bits 31 to 16 of every register read zero; software writes zero.
// - Drive slot of a pin without drive control reads 01; software writes 01.
// - Four 4-bit pin slots, highest pin on top; pull above drive in each.
`default_nettype none
package ppd_pkg;
   localparam int REG_COUNT  = 8;
   localparam int SLOT_COUNT = REG_COUNT * 4;
   localparam int ADDR_W     = 12;
   localparam int CFG_W      = 16;

   // Byte offsets of the eight configuration words
   localparam logic [ADDR_W-1:0] REG_OFFSET [REG_COUNT] = '{
      12'h238, 12'h23c, 12'h240, 12'h244, 12'h248, 12'h24c, 12'h250, 12'h254};

   // Printed reset values
   localparam logic [CFG_W-1:0] REG_RESET [REG_COUNT] = '{
      16'h9999, 16'h5959, 16'h9999, 16'h9999, 16'h0999, 16'h9000, 16'h9999, 16'h9999};

   // Bits that software may change
   localparam logic [CFG_W-1:0] REG_WMASK [REG_COUNT] = '{
      16'hffff, 16'hfcff, 16'hcccc, 16'hcccf, 16'h0ccf, 16'hc000, 16'hffff, 16'hffff};

   // Fixed value of the bits software cannot change
   localparam logic [CFG_W-1:0] REG_FIXED [REG_COUNT] = '{
      16'h0000, 16'h0100, 16'h1111, 16'h1110, 16'h0110, 16'h1000, 16'h0000, 16'h0000};

   // Slot layout
   localparam int SLOT_W     = 4;
   localparam int PULL_LSB   = 2;
   localparam int DRIVE_LSB  = 0;

   localparam logic [1:0] PULL_NONE    = 2'b00;
   localparam logic [1:0] PULL_DOWN    = 2'b01;
   localparam logic [1:0] PULL_UP      = 2'b10;
   localparam logic [1:0] DRIVE_6MA    = 2'b01;
   localparam logic [1:0] DRIVE_12MA   = 2'b11;
endpackage
`default_nettype wire

/* design/ppd_bank_if.sv */
// Carrier between the bus decode and the register storage
`default_nettype none
interface ppd_bank_if
   import ppd_pkg::*;
   ();
   logic [REG_COUNT-1:0] wr_sel;
   logic [CFG_W-1:0]     wdata;
   logic [CFG_W-1:0]     value [REG_COUNT];

   modport ctrl (output wr_sel, output wdata, input value);
   modport bank (input wr_sel, input wdata, output value);
endinterface
`default_nettype wire

/* design/ppd_bank.sv */
// Storage for the eight pad configuration words
`default_nettype none
module ppd_bank
   import ppd_pkg::*;
(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // Register access
   ppd_bank_if.bank  bus
);

   for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
      // Fixed bits are forced on every write, so a careless write cannot disturb them
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            bus.value[i] <= REG_RESET[i];
         end else if (bus.wr_sel[i]) begin
            bus.value[i] <= (bus.wdata & REG_WMASK[i]) | REG_FIXED[i];
         end
      end
   end

endmodule
`default_nettype wire

/* tb/ppd_top_sva.sv */
// Port assertions for the pad configuration bank
`default_nettype none
module ppd_sva (
   input wire logic        SYS_CLK,
   input wire logic        RST_N,
   input wire logic [11:0] ADDR,
   input wire logic [31:0] WR_DATA,
   input wire logic        WR_EN,
   input wire logic        RD_EN,
   input wire logic [31:0] RD_DATA,
   input wire logic [31:0] PAD_PULL_UP,
   input wire logic [31:0] PAD_PULL_DOWN,
   input wire logic [31:0] PAD_DRIVE_12MA
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   hi_zero_a: assert property (RD_DATA[31:16] == 16'h0)
      else $error("read upper half set");
   one_pull_a: assert property ((PAD_PULL_UP & PAD_PULL_DOWN) == 32'h0)
      else $error("both pulls on");
   // Slot 12 keeps its drive field, so it is left out of the fixed-slot mask
   fixed_drv_a: assert property ((PAD_DRIVE_12MA & 32'h00feef40) == 32'h0)
      else $error("drive on fixed slot");
   absent_pin_a: assert property (((PAD_PULL_UP | PAD_PULL_DOWN | PAD_DRIVE_12MA)
      & 32'h00780000) == 32'h0) else $error("absent pin driven");
   pull_map_a: assert property (WR_EN && ADDR == 12'h238 |-> ##2
      PAD_PULL_UP[3] == ($past(WR_DATA[15:14], 2) == 2'h2)) else $error("pull decode");
   drive_map_a: assert property (WR_EN && ADDR == 12'h250 |-> ##2
      PAD_DRIVE_12MA[27] == ($past(WR_DATA[13:12], 2) == 2'h3)) else $error("drive decode");
   // Pads stay off while reset is held, so the decode is only seen an edge later
   reset_pad_a: assert property ($rose(RST_N) |=> PAD_PULL_UP[3:0] == 4'hf
      && PAD_PULL_DOWN[7:4] == 4'ha) else $error("reset pad decode");
endmodule
bind ppd_top ppd_sva ppd_sva_i (.SYS_CLK, .RST_N, .ADDR, .WR_DATA, .WR_EN, .RD_EN,
   .RD_DATA, .PAD_PULL_UP, .PAD_PULL_DOWN, .PAD_DRIVE_12MA);
`default_nettype wire

/* tb/ppd_top_tb.sv */
// Self-checking bench for the pad configuration bank
`default_nettype none
module ppd_top_tb
   import ppd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk = 0, rst_n = 0, wr_en = 0, rd_en = 0;
   logic [11:0] addr = '0;
   logic [31:0] wr_data = '0, rd_data, pu, pd, d12;
   int          err_count = 0, checked = 0;
   always #20 sys_clk = ~sys_clk;
   ppd_top ppd_top_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .ADDR(addr), .WR_DATA(wr_data),
      .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .PAD_PULL_UP(pu),
      .PAD_PULL_DOWN(pd), .PAD_DRIVE_12MA(d12));
   task automatic print_verdict;
      if (err_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   // Strobes drop an edge before the next access, so none is set twice at once
   task automatic access(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge sys_clk);
      wr_en <= w;
      rd_en <= !w;
      addr <= a;
      wr_data <= d;
      @(posedge sys_clk);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      #1 if (!w) cmp("read data", d, rd_data);
   endtask
   initial begin
      repeat (1000) @(posedge sys_clk);
      err_count++;
      print_verdict();
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < REG_COUNT; i++) begin
         access(0, REG_OFFSET[i], {16'h0, REG_RESET[i]});
         access(1, REG_OFFSET[i], 32'hffffffff);
         access(0, REG_OFFSET[i], {16'h0, REG_WMASK[i] | REG_FIXED[i]});
         access(1, REG_OFFSET[i], 32'h0);
         access(0, REG_OFFSET[i], {16'h0, REG_FIXED[i]});
      end
      access(0, 12'h234, 32'h0);
      access(1, 12'h238, 32'h4b3d);
      @(posedge sys_clk);
      #1 cmp("pads", 32'h486, {20'h0, pu[3:0], pd[3:0], d12[3:0]});
      access(1, 12'h238, 32'h8e71);
      @(posedge sys_clk);
      #1 cmp("pads", 32'h822, {20'h0, pu[3:0], pd[3:0], d12[3:0]});
      print_verdict();
   end
endmodule
`default_nettype wire
